/* File: include/rdap_pkg.sv */
// Package with register map, field layout and constants of the day alarm and prescaler block
package rdap_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_ALARM_DOW   = 12'h000;
	localparam logic [11:0] OFF_ALARM_DOM   = 12'h004;
	localparam logic [11:0] OFF_PS0_CTL     = 12'h008;
	localparam logic [11:0] OFF_MODE        = 12'h00C;
	localparam logic [11:0] OFF_CAL_NOW     = 12'h010;
	localparam logic [11:0] OFF_IRQ_STATUS  = 12'h014;
	localparam logic [11:0] OFF_IRQ_MASK    = 12'h018;
	localparam logic [11:0] OFF_PS0_COUNT   = 12'h01C;
	// Alarm field layout
	localparam int AE_BIT     = 7;
	localparam int DOW_MSB    = 2;
	localparam int DOM_MSB    = 4;
	localparam int BCD_HI_MSB = 5;
	// Prescaler control field layout
	localparam int SSEL_BIT   = 14;
	localparam int DIV_MSB    = 13;
	localparam int DIV_LSB    = 11;
	localparam int HOLD_BIT   = 8;
	localparam int IP_MSB     = 4;
	localparam int IP_LSB     = 2;
	localparam int IE_BIT     = 1;
	localparam int IFG_BIT    = 0;
	// Mode register layout
	localparam int CAL_MODE_BIT = 0;
	localparam int BCD_BIT      = 1;
	localparam int GHOLD_BIT    = 2;
	// Interrupt status layout
	localparam int ST_PS0_BIT   = 0;
	localparam int ST_ALARM_BIT = 1;
	// Reset values and fixed codes
	localparam logic [15:0] PS0_CTL_RESET = 16'h0100;
	localparam logic [2:0]  CAL_DIV_CODE  = 3'h7;
	localparam logic [2:0]  CAL_DIV_SECOND_CODE = 3'h6;
	localparam logic [7:0]  PS_CNT_RESET  = 8'h00;
endpackage

/* File: core/rdap_sync2.sv */
// Two flip-flop synchroniser for one level from another clock domain
`timescale 1ns/1ps
module rdap_sync2
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Level in and out
	input  wire logic d,
	output logic      q
);
	logic stage1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1 <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule

/* File: core/rdap_top.sv */
// Day-of-week/day-of-month alarm registers and first prescaler control, APB slave
//
// Behaviour
// - Day-of-week alarm: enable bit 7, day 2-0 (0..6), bits 6-3 read zero.
// - Alarm enable 0 excludes a register from matching, 1 includes it.
// - Binary day-of-month alarm: day in bits 4-0, bits 6-5 read zero.
// - BCD day-of-month alarm: tens in 5-4, units in 3-0, bit 6 zero.
// - Prescaler control bits 15, 10-9 and 7-5 always read zero.
// - Bit 14 selects input: 0 auxiliary clock, 1 sub-main clock; resets 0.
// - Calendar mode ignores source select and always uses the auxiliary clock.
// - Bits 13-11 set divide 2 to 256; field resets to zero.
// - Calendar mode forces first prescaler /256, second prescaler /128.
// - Bit 8 holds the prescaler when 1; resets to 1.
// - Calendar mode ignores own hold; only global hold stops it.
// - Bits 4-2 choose interval tap /2 to /256 setting the flag; reset zero.
// - Bit 1 enables the prescaler interrupt request; resets to 0.
// - Bit 0 flag sets on each interval event; resets 0; software read/write.
// - Calendar mode feeds second prescaler from first prescaler output.
`timescale 1ns/1ps
module rdap_top
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clock sources, asynchronous pins
	input  wire logic        aux_clk_in,
	input  wire logic        sub_main_clock_in,
	// Calendar counters, same clock domain
	input  wire logic [2:0]  cal_day_of_week,
	input  wire logic [7:0]  cal_day_of_month,
	input  wire logic        cal_day_tick,
	// Prescaler outputs and interrupts
	output logic             first_prescaler_out,
	output logic             second_prescaler_src_sel,
	output logic [2:0]       second_prescaler_div_force,
	output logic             second_prescaler_force,
	output logic             first_prescaler_irq,
	output logic             alarm_event,
	output logic             irq
);
	// Mode and bus signals
	logic        cal_mode;
	logic        bcd_mode;
	logic        global_clock_hold;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	// Alarm registers
	logic        dow_enable;
	logic [2:0]  dow_value;
	logic        dom_enable;
	logic [5:0]  dom_value;
	// Prescaler control fields
	logic        first_prescaler_source_select;
	logic [2:0]  first_prescaler_divide;
	logic        first_prescaler_hold;
	logic [2:0]  first_prescaler_interval;
	logic        first_prescaler_irq_enable;
	logic        first_prescaler_irq_flag;
	// Prescaler datapath
	logic        aux_sync;
	logic        smc_sync;
	logic        src_sel;
	logic        src_level;
	logic        src_prev;
	logic        src_edge;
	logic        running;
	logic [7:0]  count;
	logic [7:0]  next_count;
	logic [2:0]  div_eff;
	logic        interval_event;
	// Interrupt block and read views
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        alarm_match;
	logic        alarm_event_now;
	logic [15:0] ctl_view;
	logic [7:0]  dow_view;
	logic [7:0]  dom_view;

	rdap_sync2 u_sync_aux
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (aux_clk_in),
		.q       (aux_sync)
	);

	rdap_sync2 u_sync_smc
	(
		.pclk    (pclk),
		.presetn (presetn),
		.d       (sub_main_clock_in),
		.q       (smc_sync)
	);

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	// Any offset outside the map is refused with pslverr
	assign hit   = (paddr == rdap_pkg::OFF_ALARM_DOW) || (paddr == rdap_pkg::OFF_ALARM_DOM)
		|| (paddr == rdap_pkg::OFF_PS0_CTL) || (paddr == rdap_pkg::OFF_MODE)
		|| (paddr == rdap_pkg::OFF_CAL_NOW) || (paddr == rdap_pkg::OFF_IRQ_STATUS)
		|| (paddr == rdap_pkg::OFF_IRQ_MASK) || (paddr == rdap_pkg::OFF_PS0_COUNT);

	// Calendar mode overrides source, divide and hold
	assign src_sel = cal_mode ? 1'b0 : first_prescaler_source_select;
	assign src_level = src_sel ? smc_sync : aux_sync;
	assign src_edge  = src_level && !src_prev;
	assign div_eff   = cal_mode ? rdap_pkg::CAL_DIV_CODE : first_prescaler_divide;
	assign running   = cal_mode ? !global_clock_hold : !first_prescaler_hold;
	assign next_count = count + 8'h01;
	// Tap bit toggling 1 to 0 marks one full period of the chosen ratio
	assign interval_event = running && src_edge
		&& count[first_prescaler_interval] && !next_count[first_prescaler_interval];

	// Mode bits live in their own register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_mode          <= 1'b0;
			bcd_mode          <= 1'b0;
			global_clock_hold <= 1'b0;
		end
		else if (wr_en && paddr == rdap_pkg::OFF_MODE)
		begin
			cal_mode          <= pwdata[rdap_pkg::CAL_MODE_BIT];
			bcd_mode          <= pwdata[rdap_pkg::BCD_BIT];
			global_clock_hold <= pwdata[rdap_pkg::GHOLD_BIT];
		end
	end

	// Alarm registers; undefined at power-up, cleared here for determinism
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dow_enable <= 1'b0;
			dow_value  <= 3'h0;
			dom_enable <= 1'b0;
			dom_value  <= 6'h00;
		end
		else if (wr_en)
		begin
			if (paddr == rdap_pkg::OFF_ALARM_DOW)
			begin
				dow_enable <= pwdata[rdap_pkg::AE_BIT];
				dow_value  <= pwdata[rdap_pkg::DOW_MSB:0];
			end
			if (paddr == rdap_pkg::OFF_ALARM_DOM)
			begin
				dom_enable <= pwdata[rdap_pkg::AE_BIT];
				if (bcd_mode)
					dom_value <= pwdata[rdap_pkg::BCD_HI_MSB:0];
				else
					dom_value <= {1'b0, pwdata[rdap_pkg::DOM_MSB:0]};
			end
		end
	end

	// Prescaler control fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_prescaler_source_select <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::SSEL_BIT];
			first_prescaler_divide   <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::DIV_MSB:rdap_pkg::DIV_LSB];
			first_prescaler_hold     <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::HOLD_BIT];
			first_prescaler_interval <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::IP_MSB:rdap_pkg::IP_LSB];
			first_prescaler_irq_enable <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::IE_BIT];
		end
		else if (wr_en && paddr == rdap_pkg::OFF_PS0_CTL)
		begin
			first_prescaler_source_select <= pwdata[rdap_pkg::SSEL_BIT];
			first_prescaler_divide   <= pwdata[rdap_pkg::DIV_MSB:rdap_pkg::DIV_LSB];
			first_prescaler_hold     <= pwdata[rdap_pkg::HOLD_BIT];
			first_prescaler_interval <= pwdata[rdap_pkg::IP_MSB:rdap_pkg::IP_LSB];
			first_prescaler_irq_enable <= pwdata[rdap_pkg::IE_BIT];
		end
	end

	// Flag: hardware set wins over a software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_prescaler_irq_flag <= rdap_pkg::PS0_CTL_RESET[rdap_pkg::IFG_BIT];
		else if (interval_event)
			first_prescaler_irq_flag <= 1'b1;
		else if (wr_en && paddr == rdap_pkg::OFF_PS0_CTL)
			first_prescaler_irq_flag <= pwdata[rdap_pkg::IFG_BIT];
	end

	// Prescaler counter; software write of counter allowed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_prev <= 1'b0;
			count    <= rdap_pkg::PS_CNT_RESET;
		end
		else
		begin
			src_prev <= src_level;
			if (wr_en && paddr == rdap_pkg::OFF_PS0_COUNT)
				count <= pwdata[7:0];
			else if (running && src_edge)
				count <= next_count;
		end
	end

	// Day alarm compare; a BCD view compares the raw digits
	always_comb
	begin
		alarm_match = (dow_enable || dom_enable)
			&& (!dow_enable || cal_day_of_week == dow_value)
			&& (!dom_enable || cal_day_of_month == {2'b00, dom_value});
	end
	assign alarm_event_now = cal_mode && cal_day_tick && alarm_match;

	// Prescaler output tap, calendar mode forces the top bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_prescaler_out <= 1'b0;
		else
			first_prescaler_out <= count[div_eff];
	end

	// Second prescaler source select and force follow calendar mode; divide code resets to 0 and is 6 from the first clock after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			second_prescaler_src_sel   <= 1'b0;
			second_prescaler_div_force <= 3'h0;
			second_prescaler_force     <= 1'b0;
		end
		else
		begin
			second_prescaler_src_sel   <= cal_mode;
			second_prescaler_div_force <= rdap_pkg::CAL_DIV_SECOND_CODE;
			second_prescaler_force     <= cal_mode;
		end
	end

	// Prescaler request and alarm pulse, registered for clean pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_prescaler_irq <= 1'b0;
			alarm_event         <= 1'b0;
		end
		else
		begin
			first_prescaler_irq <= first_prescaler_irq_flag && first_prescaler_irq_enable;
			alarm_event         <= alarm_event_now;
		end
	end

	// Level interrupt, one cycle behind status and mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// Interrupt mask register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= 2'h0;
		else if (wr_en && paddr == rdap_pkg::OFF_IRQ_MASK)
			irq_mask <= pwdata[rdap_pkg::ST_ALARM_BIT:rdap_pkg::ST_PS0_BIT];
	end

	// Sticky status, write one to clear; an event in the clear cycle is kept
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= 2'h0;
		else
			irq_status <= (irq_status
				& ~((wr_en && paddr == rdap_pkg::OFF_IRQ_STATUS)
				? pwdata[rdap_pkg::ST_ALARM_BIT:rdap_pkg::ST_PS0_BIT] : 2'h0))
				| {alarm_event_now, interval_event};
	end

	// Read views with zeroed reserved bits
	always_comb
	begin
		dow_view = {dow_enable, 4'h0, dow_value};
		if (bcd_mode)
			dom_view = {dom_enable, 1'b0, dom_value};
		else
			dom_view = {dom_enable, 2'b00, dom_value[rdap_pkg::DOM_MSB:0]};
		ctl_view = {1'b0, first_prescaler_source_select, first_prescaler_divide, 2'b00,
			first_prescaler_hold, 3'h0, first_prescaler_interval,
			first_prescaler_irq_enable, first_prescaler_irq_flag};
	end

	// Zero-wait APB answer; read data registered in setup phase
	// Unmapped offsets answer with an error and read as zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			if (rd_en)
			begin
				unique case (paddr)
					rdap_pkg::OFF_ALARM_DOW:  prdata <= {24'h0, dow_view};
					rdap_pkg::OFF_ALARM_DOM:  prdata <= {24'h0, dom_view};
					rdap_pkg::OFF_PS0_CTL:    prdata <= {16'h0, ctl_view};
					rdap_pkg::OFF_MODE:       prdata <= {29'h0, global_clock_hold, bcd_mode, cal_mode};
					rdap_pkg::OFF_CAL_NOW:    prdata <= {21'h0, cal_day_of_week, cal_day_of_month};
					rdap_pkg::OFF_IRQ_STATUS: prdata <= {30'h0, irq_status};
					rdap_pkg::OFF_IRQ_MASK:   prdata <= {30'h0, irq_mask};
					rdap_pkg::OFF_PS0_COUNT:  prdata <= {24'h0, count};
					default:                  prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

/* File: verif/rdap_assertions.sv */
// Concurrent checks on the ports of the day alarm and prescaler block
`timescale 1ns/1ps
module rdap_assertions
(
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Sources and calendar
	input wire logic        aux_clk_in,
	input wire logic        sub_main_clock_in,
	input wire logic [2:0]  cal_day_of_week,
	input wire logic [7:0]  cal_day_of_month,
	input wire logic        cal_day_tick,
	// Outputs
	input wire logic        first_prescaler_out,
	input wire logic        second_prescaler_src_sel,
	input wire logic [2:0]  second_prescaler_div_force,
	input wire logic        second_prescaler_force,
	input wire logic        first_prescaler_irq,
	input wire logic        alarm_event,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_read(logic [11:0] a);
		pready && !pwrite && paddr == a;
	endsequence
	a_zero_wait: assert property (s_setup |=> pready)
		else $error("no ready one cycle after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_ctl_rsvd: assert property (
		s_read(rdap_pkg::OFF_PS0_CTL) |-> (prdata & 32'hFFFF86E0) == 32'h0)
		else $error("reserved control bits not zero");
	a_dow_rsvd: assert property (
		s_read(rdap_pkg::OFF_ALARM_DOW) |-> (prdata & 32'hFFFFFF78) == 32'h0)
		else $error("weekday alarm zero bits set");
	a_dom_rsvd: assert property (
		s_read(rdap_pkg::OFF_ALARM_DOM) |-> (prdata & 32'hFFFFFF40) == 32'h0)
		else $error("month day alarm bit 6 set");
	a_cal_src: assert property (second_prescaler_src_sel == second_prescaler_force)
		else $error("second source not tied to calendar mode");
	a_div_force: assert property (second_prescaler_force |-> second_prescaler_div_force == 3'h6)
		else $error("second divide not forced");
	a_alarm_tick: assert property (
		alarm_event |-> $past(cal_day_tick) && second_prescaler_force)
		else $error("alarm without day tick");
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the day alarm and prescaler block
`timescale 1ns/1ps
module tb;
	localparam logic [11:0] A_DOW = rdap_pkg::OFF_ALARM_DOW;
	localparam logic [11:0] A_DOM = rdap_pkg::OFF_ALARM_DOM;
	localparam logic [11:0] A_CTL = rdap_pkg::OFF_PS0_CTL;
	localparam logic [11:0] A_MOD = rdap_pkg::OFF_MODE;
	logic        pclk, presetn, psel, penable, pwrite, aux_clk_in, sub_main_clock_in;
	logic        cal_day_tick, aux_on, sub_on, pready, pslverr, ps_out, src_sel;
	logic        force_on, ps_irq, alarm_event, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, w;
	logic [2:0]  cal_day_of_week, div_f, div_code;
	logic [7:0]  cal_day_of_month;
	logic [15:0] lfsr;
	int          err_total, n_checks, cyc, n;
	rdap_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .aux_clk_in(aux_clk_in), .sub_main_clock_in(sub_main_clock_in),
		.cal_day_of_week(cal_day_of_week), .cal_day_of_month(cal_day_of_month),
		.cal_day_tick(cal_day_tick), .first_prescaler_out(ps_out),
		.second_prescaler_src_sel(src_sel), .second_prescaler_div_force(div_f),
		.second_prescaler_force(force_on), .first_prescaler_irq(ps_irq),
		.alarm_event(alarm_event), .irq(irq));
	function logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Cycles until the prescaler output changes, 2000 if it stands
	task edge_wait();
		logic v;
		v = ps_out;
		n = 0;
		while (ps_out === v && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
	endtask
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	// Source clocks step on pclk so the divided period is exact
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (aux_on)
			aux_clk_in <= ~aux_clk_in;
		if (sub_on)
			sub_main_clock_in <= ~sub_main_clock_in;
		if (cyc == 30000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	initial
	begin
		{psel, penable, pwrite, cal_day_tick, aux_on, sub_on} = '0;
		{aux_clk_in, sub_main_clock_in, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		cal_day_of_week = '0;
		cal_day_of_month = '0;
		{err_total, n_checks, cyc} = '0;
		lfsr = 16'h0025;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, A_CTL, 0);
		chk(rd, 32'h0100);
		for (int i = 0; i < 8; i++)
		begin
			w = {rnd(), rnd()};
			apb(1, A_DOW, w);
			apb(0, A_DOW, 0);
			chk(rd, w & 32'h87);
			apb(1, A_MOD, {30'h0, w[9], 1'b0});
			apb(1, A_DOM, w);
			apb(0, A_DOM, 0);
			chk(rd, w & (w[9] ? 32'hBF : 32'h9F));
			apb(1, A_CTL, w | 32'h100);
			apb(0, A_CTL, 0);
			chk(rd, (w & 32'h791F) | 32'h100);
			repeat (2) @(posedge pclk);
			chk(ps_irq, w[1] & w[0]);
		end
		apb(1, 12'hFFC, '1);
		chk(err, 1);
		apb(0, 12'hFFC, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, A_CTL, 32'h0102);
		aux_on <= 1'b1;
		apb(1, A_CTL, 32'h0002);
		do @(posedge pclk); while (ps_irq !== 1'b1);
		chk(irq, 0);
		apb(1, rdap_pkg::OFF_IRQ_MASK, 1);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		apb(1, A_CTL, 32'h0103);
		apb(0, A_CTL, 0);
		chk(rd, 32'h0103);
		apb(1, rdap_pkg::OFF_IRQ_STATUS, 1);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		apb(1, A_CTL, 32'h4100);
		aux_on <= 1'b0;
		sub_on <= 1'b1;
		apb(1, A_CTL, 32'h4002);
		do @(posedge pclk); while (ps_irq !== 1'b1);
		apb(1, A_CTL, 32'h4100);
		apb(1, A_MOD, 1);
		repeat (2) @(posedge pclk);
		chk({force_on, src_sel, div_f}, 5'h1E);
		apb(1, A_DOM, 0);
		apb(1, A_DOW, 32'h83);
		for (int k = 0; k < 28; k++)
		begin
			if (k == 14)
				apb(1, A_DOM, 32'h85);
			@(posedge pclk);
			cal_day_of_week <= 3'(k % 7);
			cal_day_of_month <= ((k / 7) % 2) ? 8'h05 : 8'h09;
			cal_day_tick <= 1'b1;
			@(posedge pclk);
			cal_day_tick <= 1'b0;
			#1 chk(alarm_event, k % 7 == 3 && (k < 14 || (k / 7) % 2 == 1));
		end
		sub_on <= 1'b0;
		aux_on <= 1'b1;
		edge_wait();
		edge_wait();
		chk(n, 256);
		apb(1, A_MOD, 5);
		edge_wait();
		chk(n, 2000);
		div_code = 3'(rnd());
		apb(1, A_CTL, {18'h0, div_code, 11'h0});
		apb(1, A_MOD, 0);
		edge_wait();
		edge_wait();
		edge_wait();
		chk(n, 2 << div_code);
		report_and_stop();
	end
endmodule
bind rdap_top rdap_assertions chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .aux_clk_in(aux_clk_in),
	.sub_main_clock_in(sub_main_clock_in), .cal_day_of_week(cal_day_of_week),
	.cal_day_of_month(cal_day_of_month), .cal_day_tick(cal_day_tick),
	.first_prescaler_out(first_prescaler_out), .second_prescaler_src_sel(second_prescaler_src_sel),
	.second_prescaler_div_force(second_prescaler_div_force),
	.second_prescaler_force(second_prescaler_force), .first_prescaler_irq(first_prescaler_irq),
	.alarm_event(alarm_event), .irq(irq));
